/* prs_consts.svh */
// Constants of the pin remap and slew block.
// Assumes inclusion by the package and the bench.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_AW 4
`define PRS_DW 16
`define PRS_NSLEW 16
`define PRS_NBIDIR 4
`define PRS_NPIN 6
`define PRS_NPIN_IN 6
`define PRS_SELW 8
`define PRS_OSELW 6
// Register offsets
`define PRS_A_SLEW_HI 4'h0
`define PRS_A_SLEW_LO 4'h1
`define PRS_A_IN_SEL0 4'h2
`define PRS_A_IN_SEL1 4'h3
`define PRS_A_IN_SEL2 4'h4
`define PRS_A_OMAP8 4'h5
`define PRS_A_OMAP9 4'h6
`define PRS_A_CTRL 4'h7
`define PRS_A_KEY 4'h8
`define PRS_A_PINS 4'h9
`define PRS_UNLOCK_KEY 16'h55_AA
`define PRS_RST16 16'h0000
// Slew pins that implement selection
`define PRS_SLEW_MASK 16'hFFFF
// Remappable pin numbers, bidir first, then input only
`define PRS_RP69 8'h45
`define PRS_RP70 8'h46
`define PRS_RP97 8'h61
`define PRS_RP118 8'h76
`define PRS_RPI32 8'h20
`define PRS_RPI33 8'h21
// Output function codes
`define PRS_FN_NONE 6'h00
`define PRS_FN_UTX 6'h01
`define PRS_FN_SDO 6'h02
`define PRS_FN_SCK 6'h03
`define PRS_FN_OC1 6'h04
// Slowdown factors
`define PRS_SR_FAST 5'h01
`define PRS_SR_X4 5'h04
`define PRS_SR_X8 5'h08
`define PRS_SR_X16 5'h10
`endif

/* prs_pkg.sv */
// Types of the pin remap and slew block.
// Assumes prs_consts.svh is on the include path.
`include "prs_consts.svh"
package prs_pkg;
	typedef struct packed {
		logic [`PRS_NSLEW-1:0] slew_hi;
		logic [`PRS_NSLEW-1:0] slew_lo;
		logic [`PRS_NSLEW-1:0] slew_fast;
		logic [`PRS_NPIN_IN-1:0][`PRS_SELW-1:0] in_sel;
		logic [`PRS_NBIDIR-1:0][`PRS_OSELW-1:0] out_sel;
		logic locked;
		logic one_way;
		logic started;
		logic key_ok;
		logic [`PRS_NBIDIR-1:0] pad_out;
		logic [`PRS_NBIDIR-1:0] pad_oe;
		logic [`PRS_NPIN_IN-1:0] periph_in;
		logic [`PRS_NPIN-1:0] pin_seen;
		logic [`PRS_DW-1:0] rdata;
	} prs_state_type;
endpackage : prs_pkg

/* prs_remap.sv */
// Slew selection registers and remappable pin matrix for one port.
// Assumes a single 20 MHz clock, synchronous inputs and a register
// master that never needs to be stalled.
// What this block does
// - Two slew registers per port; high gives MSb, low gives LSb.
// - Code 00 fastest, 01 four, 10 eight, 11 sixteen times slower.
// - Slew bits drive slew-capable pins directly, unqualified.
// - Inputs and outputs route independently over a fixed pin subset.
// - A hardware guard blocks spurious mapping changes once set.
// - Bidir pins take inputs and outputs; input-only pins take inputs.
// - Remappable peripherals have no default pin until assigned.
// - Non-remappable peripherals use their fixed pin when active.
// - Active remapped output beats GPIO and other digital functions.
// - Analog function on a pin always beats remapped peripherals.
// - Two-wire serial, PWM and analog stay on dedicated pins.
// - Matrix covers UART, SPI, timer clock, capture, compare, change.
// - Input routing and output routing use separate registers.
// - Each remappable peripheral input owns a select field.
// - Input select is 8 bits; value n picks remappable pin n.
// - Only implemented pin numbers are legal select values.
// - Map register eight: 13-8 drive pin 70, 5-0 drive pin 69.
// - Map register nine: 13-8 drive pin 118, 5-0 drive pin 97.
// - Map bits 15-14 and 7-6 read as zero.
// - Lock strap set allows one reconfiguration, clear allows many.
//
// The placing of the registers and the plain strobed port were left to the implementer.
module prs_remap
	import prs_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [`PRS_AW-1:0] reg_addr, // Register offset
	input wire logic [`PRS_DW-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [`PRS_DW-1:0] reg_rdata, // Read data, next cycle
	input wire logic single_remap_lock, // Strap: one reconfiguration
	output logic map_locked, // Mapping guard closed
	output logic [`PRS_NSLEW-1:0] pin_slew_msb, // Slew code MSb
	output logic [`PRS_NSLEW-1:0] pin_slew_lsb, // Slew code LSb
	output logic [`PRS_NSLEW-1:0] pin_slew_fast, // Fastest edge
	input wire logic [`PRS_NPIN-1:0] pad_in, // Pad levels
	input wire logic [`PRS_NPIN-1:0] analog_sel, // Pin owned by analog
	input wire logic [`PRS_NBIDIR-1:0] gpio_out, // Port latch
	input wire logic [`PRS_NBIDIR-1:0] gpio_oe, // Port direction
	input wire logic [`PRS_NBIDIR-1:0] fixed_en, // Dedicated fn active
	input wire logic [`PRS_NBIDIR-1:0] fixed_out, // Dedicated fn data
	input wire logic [`PRS_NBIDIR-1:0] fixed_oe, // Dedicated fn enable
	input wire logic uart_tx, // UART transmit
	input wire logic spi_sdo, // SPI data out
	input wire logic spi_sck_out, // SPI clock out
	input wire logic oc1_out, // Output compare
	output logic [`PRS_NBIDIR-1:0] pad_out, // Pad data
	output logic [`PRS_NBIDIR-1:0] pad_oe, // Pad drive enable
	output logic [`PRS_NPIN_IN-1:0] periph_in // Routed inputs
);
	import prs_pkg::*;

	prs_state_type q;
	prs_state_type d;

	function automatic logic [7:0] pin_num(input int i);
		unique case (i)
			0: pin_num = `PRS_RP69;
			1: pin_num = `PRS_RP70;
			2: pin_num = `PRS_RP97;
			3: pin_num = `PRS_RP118;
			4: pin_num = `PRS_RPI32;
			default: pin_num = `PRS_RPI33;
		endcase
	endfunction : pin_num

	// Selected pin level; unknown numbers give 0, no default pin
	function automatic logic route_in(input logic [7:0] sel,
		input logic [`PRS_NPIN-1:0] lvl);
		route_in = 1'b0;
		for (int i = 0; i < `PRS_NPIN; i++) begin
			if (sel == pin_num(i)) begin
				route_in = lvl[i];
			end
		end
	endfunction : route_in

	// Output function lookup; bit 1 is active, bit 0 the data
	function automatic logic [1:0] route_out(input logic [5:0] fn,
		input logic [3:0] src);
		unique case (fn)
			`PRS_FN_UTX: route_out = {1'b1, src[0]};
			`PRS_FN_SDO: route_out = {1'b1, src[1]};
			`PRS_FN_SCK: route_out = {1'b1, src[2]};
			`PRS_FN_OC1: route_out = {1'b1, src[3]};
			default: route_out = 2'b00;
		endcase
	endfunction : route_out

	// Slowdown factor of a slew code
	function automatic logic [4:0] slew_ratio(input logic [1:0] c);
		unique case (c)
			2'b00: slew_ratio = `PRS_SR_FAST;
			2'b01: slew_ratio = `PRS_SR_X4;
			2'b10: slew_ratio = `PRS_SR_X8;
			default: slew_ratio = `PRS_SR_X16;
		endcase
	endfunction : slew_ratio

	function automatic logic [15:0] map_word(input logic [5:0] hi,
		input logic [5:0] lo);
		map_word = {2'b00, hi, 2'b00, lo};
	endfunction : map_word

	logic wr_map;
	logic [3:0] src;
	logic [1:0] rt;
	logic [7:0] sel;

	always_comb begin
		d = q;
		wr_map = 1'b0;
		src = {oc1_out, spi_sck_out, spi_sdo, uart_tx};
		rt = 2'b00;
		sel = 8'h00;
		d.rdata = `PRS_RST16;
		// Strap is caught on the first cycle after reset release
		if (!q.started) begin
			d.started = 1'b1;
			d.one_way = single_remap_lock;
		end
		if (reg_wr) begin
			d.key_ok = (reg_addr == `PRS_A_KEY) && (reg_wdata == `PRS_UNLOCK_KEY);
			unique case (reg_addr)
				`PRS_A_SLEW_HI: d.slew_hi = reg_wdata;
				`PRS_A_SLEW_LO: d.slew_lo = reg_wdata;
				`PRS_A_CTRL: begin
					if (reg_wdata[0]) begin
						d.locked = 1'b1;
					end else if (q.key_ok && !q.one_way) begin
						d.locked = 1'b0;
					end
				end
				default: wr_map = !q.locked;
			endcase
			if (wr_map) begin
				unique case (reg_addr)
					`PRS_A_IN_SEL0: d.in_sel[1:0] = {reg_wdata[15:8], reg_wdata[7:0]};
					`PRS_A_IN_SEL1: d.in_sel[3:2] = {reg_wdata[15:8], reg_wdata[7:0]};
					`PRS_A_IN_SEL2: d.in_sel[5:4] = {reg_wdata[15:8], reg_wdata[7:0]};
					`PRS_A_OMAP8: begin
						d.out_sel[1] = reg_wdata[13:8];
						d.out_sel[0] = reg_wdata[5:0];
					end
					`PRS_A_OMAP9: begin
						d.out_sel[3] = reg_wdata[13:8];
						d.out_sel[2] = reg_wdata[5:0];
					end
					default: d.key_ok = d.key_ok;
				endcase
			end
		end else if (reg_rd) begin
			d.key_ok = 1'b0;
			unique case (reg_addr)
				`PRS_A_SLEW_HI: d.rdata = q.slew_hi;
				`PRS_A_SLEW_LO: d.rdata = q.slew_lo;
				`PRS_A_IN_SEL0: d.rdata = {q.in_sel[1], q.in_sel[0]};
				`PRS_A_IN_SEL1: d.rdata = {q.in_sel[3], q.in_sel[2]};
				`PRS_A_IN_SEL2: d.rdata = {q.in_sel[5], q.in_sel[4]};
				`PRS_A_OMAP8: d.rdata = map_word(q.out_sel[1], q.out_sel[0]);
				`PRS_A_OMAP9: d.rdata = map_word(q.out_sel[3], q.out_sel[2]);
				`PRS_A_CTRL: d.rdata = {14'h0000, q.one_way, q.locked};
				`PRS_A_PINS: d.rdata = {10'h000, q.pin_seen};
				default: d.rdata = `PRS_RST16;
			endcase
		end
		// Slew bits go out unqualified on capable pins
		d.slew_fast = ~(d.slew_hi | d.slew_lo) & `PRS_SLEW_MASK;
		d.pin_seen = pad_in;
		// Input matrix; analog owned pins read low
		for (int p = 0; p < `PRS_NPIN_IN; p++) begin
			sel = q.in_sel[p];
			d.periph_in[p] = route_in(sel, pad_in & ~analog_sel);
		end
		// Pin priority: analog, remapped, dedicated, port
		for (int k = 0; k < `PRS_NBIDIR; k++) begin
			rt = route_out(q.out_sel[k], src);
			if (analog_sel[k]) begin
				d.pad_out[k] = 1'b0;
				d.pad_oe[k] = 1'b0;
			end else if (rt[1]) begin
				d.pad_out[k] = rt[0];
				d.pad_oe[k] = 1'b1;
			end else if (fixed_en[k]) begin
				d.pad_out[k] = fixed_out[k];
				d.pad_oe[k] = fixed_oe[k];
			end else begin
				d.pad_out[k] = gpio_out[k];
				d.pad_oe[k] = gpio_oe[k];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			// Code 00 after reset is the fastest edge, so the flag starts set
			q.slew_fast <= `PRS_SLEW_MASK;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign map_locked = q.locked;
	assign pin_slew_msb = q.slew_hi;
	assign pin_slew_lsb = q.slew_lo;
	assign pin_slew_fast = q.slew_fast;
	assign pad_out = q.pad_out;
	assign pad_oe = q.pad_oe;
	assign periph_in = q.periph_in;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_slew_low_write: assert property (
		reg_wr && reg_addr == `PRS_A_SLEW_LO |=> pin_slew_lsb == $past(reg_wdata))
		else $error("slew low register not updated");

	chk_slew_code_decode: assert property (
		pin_slew_fast[0] == (slew_ratio({pin_slew_msb[0], pin_slew_lsb[0]}) == `PRS_SR_FAST))
		else $error("fast slew flag disagrees with code");

	chk_locked_map_held: assert property (
		map_locked && reg_wr && reg_addr == `PRS_A_OMAP8 |=> $stable(q.out_sel))
		else $error("locked mapping changed by write");

	chk_one_way_sticky: assert property (
		map_locked && q.one_way |=> map_locked)
		else $error("one-way lock was released");

	chk_analog_wins: assert property (
		analog_sel[0] |=> !pad_oe[0] && !pad_out[0])
		else $error("digital drive on analog pin");

	chk_remap_drives: assert property (
		q.out_sel[1] == `PRS_FN_UTX && !analog_sel[1]
		|=> pad_oe[1] && pad_out[1] == $past(uart_tx))
		else $error("remapped output lost priority");

	chk_fixed_default: assert property (
		q.out_sel[2] == `PRS_FN_NONE && fixed_en[2] && !analog_sel[2]
		|=> pad_out[2] == $past(fixed_out[2]) && pad_oe[2] == $past(fixed_oe[2]))
		else $error("dedicated function not on its pin");

	chk_zero_sel_port: assert property (
		q.out_sel[3] == `PRS_FN_NONE && !fixed_en[3] && !analog_sel[3]
		|=> pad_out[3] == $past(gpio_out[3]))
		else $error("port data not on unmapped pin");

	chk_map_unimpl_zero: assert property (
		reg_rd && reg_addr == `PRS_A_OMAP9 |=> reg_rdata[15:14] == 2'b00 && reg_rdata[7:6] == 2'b00)
		else $error("unimplemented map bits read nonzero");

	chk_input_route: assert property (
		q.in_sel[0] == `PRS_RP70 && !analog_sel[1] |=> periph_in[0] == $past(pad_in[1]))
		else $error("input not routed from selected pin");

	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == `PRS_RST16)
		else $error("read data outside read slot");

	chk_slew_high_write: assert property (
		reg_wr && reg_addr == `PRS_A_SLEW_HI |=> pin_slew_msb == $past(reg_wdata))
		else $error("slew high register not updated");

	chk_slew_hi_hold: assert property (
		!(reg_wr && reg_addr == `PRS_A_SLEW_HI) |=> $stable(pin_slew_msb))
		else $error("slew msb changed without a write");

	chk_slew_lo_hold: assert property (
		!(reg_wr && reg_addr == `PRS_A_SLEW_LO) |=> $stable(pin_slew_lsb))
		else $error("slew lsb changed without a write");

	chk_slew_fast_all: assert property (
		pin_slew_fast == ~(pin_slew_msb | pin_slew_lsb))
		else $error("fast slew flags disagree with codes");

	chk_slew_slow_code: assert property (
		pin_slew_msb[1] |-> !pin_slew_fast[1])
		else $error("slow code flagged as fastest");

	chk_lock_sets: assert property (
		reg_wr && reg_addr == `PRS_A_CTRL && reg_wdata[0] |=> map_locked)
		else $error("lock write did not close guard");

	chk_unlock_needs_ctrl: assert property (
		map_locked && !(reg_wr && reg_addr == `PRS_A_CTRL && !reg_wdata[0]) |=> map_locked)
		else $error("guard opened without control write");

	chk_omap9_held: assert property (
		map_locked && reg_wr && reg_addr == `PRS_A_OMAP9 |=> $stable(q.out_sel))
		else $error("locked map nine changed by write");

	chk_insel_held: assert property (
		map_locked && reg_wr
		&& reg_addr inside {`PRS_A_IN_SEL0, `PRS_A_IN_SEL1, `PRS_A_IN_SEL2}
		|=> $stable(q.in_sel))
		else $error("locked input select changed by write");

	chk_omap8_low: assert property (
		!map_locked && reg_wr && reg_addr == `PRS_A_OMAP8 |=> q.out_sel[0] == $past(reg_wdata[5:0]))
		else $error("pin 69 select not written");

	chk_omap8_high: assert property (
		!map_locked && reg_wr && reg_addr == `PRS_A_OMAP8
		|=> q.out_sel[1] == $past(reg_wdata[13:8]))
		else $error("pin 70 select not written");

	chk_omap9_write: assert property (
		!map_locked && reg_wr && reg_addr == `PRS_A_OMAP9
		|=> q.out_sel[2] == $past(reg_wdata[5:0]) && q.out_sel[3] == $past(reg_wdata[13:8]))
		else $error("pin 97 or 118 select not written");

	chk_insel_write: assert property (
		!map_locked && reg_wr && reg_addr == `PRS_A_IN_SEL0
		|=> q.in_sel[0] == $past(reg_wdata[7:0]) && q.in_sel[1] == $past(reg_wdata[15:8]))
		else $error("input select fields not written");

	chk_map8_unimpl: assert property (
		reg_rd && reg_addr == `PRS_A_OMAP8 |=> reg_rdata[15:14] == 2'b00 && reg_rdata[7:6] == 2'b00)
		else $error("map eight unimplemented bits nonzero");

	chk_map8_readback: assert property (
		reg_rd && reg_addr == `PRS_A_OMAP8 |=> reg_rdata[5:0] == $past(q.out_sel[0]))
		else $error("map eight read back wrong");

	chk_analog_all: assert property (
		1'b1 |=> (pad_oe & $past(analog_sel[3:0])) == 4'h0
		&& (pad_out & $past(analog_sel[3:0])) == 4'h0)
		else $error("digital drive on an analog pin");

	chk_analog_input: assert property (
		analog_sel[0] && q.in_sel[0] == `PRS_RP69 |=> !periph_in[0])
		else $error("analog pin level routed to input");

	chk_remap_over_fixed: assert property (
		q.out_sel[0] == `PRS_FN_SDO && fixed_en[0] && !analog_sel[0]
		|=> pad_oe[0] && pad_out[0] == $past(spi_sdo))
		else $error("dedicated function beat remapped output");

	chk_remap_sck: assert property (
		q.out_sel[3] == `PRS_FN_SCK && !analog_sel[3]
		|=> pad_oe[3] && pad_out[3] == $past(spi_sck_out))
		else $error("serial clock not on mapped pin");

	chk_remap_oc1: assert property (
		q.out_sel[2] == `PRS_FN_OC1 && !analog_sel[2]
		|=> pad_oe[2] && pad_out[2] == $past(oc1_out))
		else $error("compare output not on mapped pin");

	chk_no_default_pin: assert property (
		q.in_sel[5] == 8'h00 |=> !periph_in[5])
		else $error("unassigned input took a pin");

	chk_input_only_pin: assert property (
		q.in_sel[4] == `PRS_RPI32 && !analog_sel[4] |=> periph_in[4] == $past(pad_in[4]))
		else $error("input-only pin not routed");

	chk_invalid_sel: assert property (
		q.in_sel[3] == 8'hFF |=> !periph_in[3])
		else $error("unimplemented pin number routed");

	chk_fixed_oe: assert property (
		q.out_sel[1] == `PRS_FN_NONE && fixed_en[1] && !analog_sel[1]
		|=> pad_oe[1] == $past(fixed_oe[1]))
		else $error("dedicated enable not on its pin");

	chk_gpio_oe: assert property (
		q.out_sel[0] == `PRS_FN_NONE && !fixed_en[0] && !analog_sel[0]
		|=> pad_oe[0] == $past(gpio_oe[0]))
		else $error("port direction not on unmapped pin");

	chk_ctrl_readback: assert property (
		reg_rd && reg_addr == `PRS_A_CTRL
		|=> reg_rdata == {14'h0000, $past(q.one_way), $past(map_locked)})
		else $error("control read back wrong");

	chk_strap_capture: assert property (
		$past(rst) && !rst |=> q.one_way == $past(single_remap_lock))
		else $error("lock strap not captured");

	chk_pins_status: assert property (
		reg_rd && reg_addr == `PRS_A_PINS |=> reg_rdata == {10'h000, $past(q.pin_seen)})
		else $error("pin status read back wrong");

	chk_unmapped_read: assert property (
		reg_rd && reg_addr > `PRS_A_PINS |=> reg_rdata == `PRS_RST16)
		else $error("unmapped offset read nonzero");

endmodule : prs_remap

/* prs_periph_model.sv */
// Far-side model: digital peripheral outputs and pad levels.
// Assumes the bench changes the levels just after a rising clock edge.
module prs_periph_model (
	input wire logic [3:0] fn_lvl, // Peripheral levels, compare/sck/sdo/tx
	input wire logic [5:0] pin_lvl, // Pad levels
	output logic uart_tx, // UART transmit
	output logic spi_sdo, // SPI data out
	output logic spi_sck_out, // SPI clock out
	output logic oc1_out, // Output compare
	output logic [5:0] pad_in // Pad levels seen by the block
);
	timeunit 1ns;
	timeprecision 1ps;
	// Peripherals run whether or not a pin has been assigned
	assign {oc1_out, spi_sck_out, spi_sdo, uart_tx} = fn_lvl;
	assign pad_in = pin_lvl;
endmodule : prs_periph_model

/* prs_remap_tb_top.sv */
// Self-checking bench of the pin remap and slew block.
// Assumes prs_pkg, prs_remap and prs_periph_model are compiled first.
`include "prs_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module prs_remap_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic strap = 1'b0;
	logic lock_e = 1'b0;
	logic rd_p1 = 1'b0;
	logic [2:0] sel_smp = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, exp_v, got_v, slew_h, slew_l, slew_msb, slew_lsb, slew_fast;
	logic [3:0] g_out = 4'h0, g_oe = 4'h0, f_en = 4'h0, f_out = 4'h0, f_oe = 4'h0, fn = 4'h0;
	logic [3:0] pad_out, pad_oe;
	logic [5:0] lvl = 6'h00, an = 6'h00, periph_in;
	logic map_locked;
	logic [5:0] code [4];
	logic [7:0] isel [6];
	logic [7:0] pnum [6];
	logic [31:0] seed = 32'h0000_9929;
	logic [15:0] q [$];
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	wire uart_tx, spi_sdo, spi_sck_out, oc1_out;
	wire [5:0] pad_in;

	always #25 sys_clk = ~sys_clk;

	prs_periph_model far (.fn_lvl(fn), .pin_lvl(lvl), .uart_tx(uart_tx), .spi_sdo(spi_sdo),
		.spi_sck_out(spi_sck_out), .oc1_out(oc1_out), .pad_in(pad_in));
	prs_remap dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .single_remap_lock(strap),
		.map_locked(map_locked), .pin_slew_msb(slew_msb), .pin_slew_lsb(slew_lsb),
		.pin_slew_fast(slew_fast), .pad_in(pad_in), .analog_sel(an), .gpio_out(g_out),
		.gpio_oe(g_oe), .fixed_en(f_en), .fixed_out(f_out), .fixed_oe(f_oe), .uart_tx(uart_tx),
		.spi_sdo(spi_sdo), .spi_sck_out(spi_sck_out), .oc1_out(oc1_out), .pad_out(pad_out),
		.pad_oe(pad_oe), .periph_in(periph_in));

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt

	// Pin vector as the watcher sees it: lock, pad data, pad enables, routed inputs
	function automatic logic [15:0] pins_exp();
		logic [3:0] o, e;
		logic [5:0] p;
		for (int i = 0; i < 4; i++) begin
			if (an[i]) {o[i], e[i]} = 2'b00;
			else if (code[i] inside {[1:4]}) {o[i], e[i]} = {fn[code[i] - 1], 1'b1};
			else if (f_en[i]) {o[i], e[i]} = {f_out[i], f_oe[i]};
			else {o[i], e[i]} = {g_out[i], g_oe[i]};
		end
		for (int k = 0; k < 6; k++) begin
			p[k] = 1'b0;
			for (int j = 0; j < 6; j++)
				if (isel[k] == pnum[j]) p[k] = lvl[j] & ~an[j];
		end
		return {1'b0, lock_e, o, e, p};
	endfunction : pins_exp

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic smp(input logic [2:0] s, input logic [15:0] e);
		@(posedge sys_clk);
		sel_smp <= s;
		q.push_back(e);
		@(posedge sys_clk);
		sel_smp <= 3'h0;
	endtask : smp

	task automatic setmap();
		wr(`PRS_A_OMAP8, {2'b00, code[1], 2'b00, code[0]});
		wr(`PRS_A_OMAP9, {2'b00, code[3], 2'b00, code[2]});
		for (int k = 0; k < 3; k++) wr(4'(`PRS_A_IN_SEL0 + k), {isel[2 * k + 1], isel[2 * k]});
	endtask : setmap

	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		code = '{default: '0};
		isel = '{default: '0};
	endtask : do_reset

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// Takes the oldest expectation whenever a read answer or a sample is due
	always @(posedge sys_clk) begin
		if (rd_p1 || sel_smp != 3'h0) begin
			exp_v = q.pop_front();
			case (sel_smp)
				3'h1: got_v = {1'b0, map_locked, pad_out, pad_oe, periph_in};
				3'h2: got_v = slew_msb;
				3'h3: got_v = slew_lsb;
				3'h4: got_v = slew_fast;
				default: got_v = reg_rdata;
			endcase
			`CHK(got_v, exp_v)
		end
		rd_p1 <= reg_rd;
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			finish_test();
		end
	end

	initial begin
		pnum = '{`PRS_RP69, `PRS_RP70, `PRS_RP97, `PRS_RP118, `PRS_RPI32, `PRS_RPI33};
		do_reset();
		for (int a = 0; a < 8; a++) rd(4'(a), 16'h0000);
		$display("reset values done");
		repeat (2) begin
			seed = nxt(seed);
			slew_h = seed[15:0];
			seed = nxt(seed);
			slew_l = seed[15:0];
			wr(`PRS_A_SLEW_HI, slew_h);
			wr(`PRS_A_SLEW_LO, slew_l);
			rd(`PRS_A_SLEW_HI, slew_h);
			smp(3'h2, slew_h);
			smp(3'h3, slew_l);
			smp(3'h4, ~(slew_h | slew_l));
		end
		$display("slew done");
		wr(`PRS_A_OMAP8, 16'hFFFF);
		rd(`PRS_A_OMAP8, 16'h3F3F);
		wr(`PRS_A_OMAP9, 16'hFFFF);
		rd(`PRS_A_OMAP9, 16'h3F3F);
		wr(4'hA, 16'h1234);
		rd(4'hA, 16'h0000);
		for (int c = 0; c < 7; c++) begin
			for (int i = 0; i < 4; i++) code[i] = 6'((c + i) % 6);
			for (int k = 0; k < 6; k++) isel[k] = ((c + k) % 7 == 6) ? 8'h00 : pnum[(c + k) % 7];
			setmap();
			seed = nxt(seed);
			{g_out, g_oe, f_en, f_out, f_oe, fn} <= seed[23:0];
			seed = nxt(seed);
			{lvl, an} <= {seed[5:0], seed[11:6] & seed[17:12]};
			#1;
			smp(3'h1, pins_exp());
			rd(`PRS_A_PINS, {10'h000, lvl});
		end
		$display("routing done");
		wr(`PRS_A_CTRL, 16'h0001);
		lock_e = 1'b1;
		wr(`PRS_A_OMAP8, 16'h0101);
		wr(`PRS_A_IN_SEL0, 16'hFFFF);
		rd(`PRS_A_OMAP8, {2'b00, code[1], 2'b00, code[0]});
		smp(3'h1, pins_exp());
		wr(`PRS_A_KEY, 16'h1234);
		wr(`PRS_A_CTRL, 16'h0000);
		rd(`PRS_A_CTRL, 16'h0001);
		wr(`PRS_A_KEY, `PRS_UNLOCK_KEY);
		wr(`PRS_A_CTRL, 16'h0000);
		rd(`PRS_A_CTRL, 16'h0000);
		lock_e = 1'b0;
		wr(`PRS_A_OMAP8, 16'h0101);
		rd(`PRS_A_OMAP8, 16'h0101);
		$display("lock done");
		strap <= 1'b1;
		do_reset();
		smp(3'h1, pins_exp());
		wr(`PRS_A_CTRL, 16'h0001);
		lock_e = 1'b1;
		wr(`PRS_A_KEY, `PRS_UNLOCK_KEY);
		wr(`PRS_A_CTRL, 16'h0000);
		rd(`PRS_A_CTRL, 16'h0003);
		wr(`PRS_A_OMAP8, 16'h0101);
		rd(`PRS_A_OMAP8, 16'h0000);
		wr(`PRS_A_SLEW_HI, 16'hA5A5);
		rd(`PRS_A_SLEW_HI, 16'hA5A5);
		$display("one-way lock done");
		repeat (3) @(posedge sys_clk);
		finish_test();
	end
endmodule : prs_remap_tb_top
